// File: dv/pci_master_model.sv
/*
 * Register master model for the protected command interface.
 * Assumes callers enter each task 1 ns after a rising clock edge.
 */
`timescale 1ns/1ps
`default_nettype none

module pci_master_model
    import pci_pkg::*;
(
    input  wire logic     ref_clk_in,
    output pci_req_s      req_out,
    input  wire pci_rsp_s rsp_in
);
    initial req_out = '0;

    // ---------------------------------------------------------------
    // Bus cycles
    // ---------------------------------------------------------------
    task automatic send(input logic w, input logic [15:0] a, input logic [15:0] d,
                        input logic l);
        req_out = '{valid: 1'b1, write: w, last: l, addr: a, data: d};
        @(posedge ref_clk_in);
        #1;
    endtask

    // A released bus shows inverted values so stale data is never mistaken for valid.
    // One idle edge follows, so valid never drops and rises in the same time step.
    task automatic release_bus();
        req_out.valid = 1'b0;
        req_out.addr  = ~req_out.addr;
        req_out.data  = ~req_out.data;
        @(posedge ref_clk_in);
        #1;
    endtask

    task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic e);
        send(1'b0, a, 16'h0000, 1'b1);
        d = rsp_in.data;
        e = rsp_in.err;
        release_bus();
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d, output logic e);
        send(1'b1, a, d, 1'b1);
        e = rsp_in.err;
        release_bus();
    endtask

    // The whole buffer goes out as one multiple-register write from the command word.
    task automatic frame(input logic [19:0][15:0] b);
        for (int i = 0; i < 20; i++) begin
            send(1'b1, ADDR_CMD + 16'(i), b[i], i == 19);
        end
        release_bus();
    endtask
endmodule // pci_master_model

`default_nettype wire

// File: dv/protected_command_interface_tb.sv
/*
 * Self-checking testbench for the protected command interface.
 * Assumes the master model drives all register traffic.
 */
`timescale 1ns/1ps
`default_nettype none

module protected_command_interface_tb;
    import pci_pkg::*;

    localparam logic [7:0] MA = 8'h12;
    logic ref_clk_in = 1'b0, sys_rst_in = 1'b1, lck = 1'b0, drw = 1'b0, unl = 1'b0;
    pci_req_s req;
    pci_rsp_s rsp;
    logic busy, xv;
    logic [15:0] xcode, xarg;
    logic [31:0] pw_tb [4] = '{32'h30303030, 32'h31313131, 32'h32323232, 32'h33333333};
    int n_errors = 0, n_checks = 0, n_exec = 0, n_req = 0, n_rsp = 0;

    always #4 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) if (xv === 1'b1) n_exec++;
    always @(posedge ref_clk_in) if (req.valid === 1'b1) n_req++;
    always @(posedge ref_clk_in) if (rsp.valid === 1'b1) n_rsp++;

    pci_master_model m (.ref_clk_in(ref_clk_in), .req_out(req), .rsp_in(rsp));
    pci_cmd_if #(.MODULE_ADDR(MA)) dut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
        .req_in(req), .rsp_out(rsp), .lock_open_in(lck), .drawout_variant_in(drw),
        .intrusive_unlocked_in(unl), .busy_out(busy), .exec_valid_out(xv),
        .exec_code_out(xcode), .exec_arg_out(xarg));

    // ---------------------------------------------------------------
    // Checking and expectations
    // ---------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    function automatic logic fmt(input logic [31:0] p);
        logic ok = 1'b1;
        for (int i = 0; i < 4; i++) begin
            ok &= (p[8*i+:8] inside {[8'h30:8'h39], [8'h41:8'h5a], [8'h61:8'h7a]});
        end
        return ok;
    endfunction

    function automatic logic [15:0] exp_st(input logic [15:0] c, l, input logic [31:0] p,
                                           input logic [15:0] a0, a1, a2);
        logic ok;
        if (!(c inside {CMD_READ_STATE, CMD_OPEN_BREAKER, CMD_CLOSE_BREAKER,
                        CMD_SET_PASSWORD})) return {MA, 8'h0d};
        if (l < 16'h000a || l > 16'h001e) return {MA, 8'h0c};
        if (c == CMD_READ_STATE) return 16'h0000;
        if (!(drw ? unl : lck)) return {MA, 8'h0e};
        if (c != CMD_SET_PASSWORD) ok = p == pw_tb[0] || p == pw_tb[2] || p == pw_tb[3];
        else ok = p == pw_tb[0] || p == pw_tb[a0[1:0]];
        if (!ok) return {MA, 8'h01};
        if (c == CMD_SET_PASSWORD && !fmt({a1, a2})) return {MA, 8'h0c};
        return 16'h0000;
    endfunction

    function automatic logic [19:0][15:0] mk(input logic [15:0] c, l, input logic [31:0] p,
                                             input logic [15:0] a0, a1, a2);
        logic [19:0][15:0] b = '0;
        b[0]  = c;
        b[1]  = l;
        b[3]  = {15'h0, c != CMD_READ_STATE};
        b[4]  = p[31:16];
        b[5]  = p[15:0];
        b[6]  = a0;
        b[7]  = a1;
        b[8]  = a2;
        b[17] = 16'h1f53;
        b[18] = 16'h1f54;
        b[19] = 16'h1f55;
        return b;
    endfunction

    task automatic do_cmd(input logic [15:0] c, l, input logic [31:0] p,
                          input logic [15:0] a0, a1, a2);
        logic [15:0] ex, st, st0, d;
        logic e;
        int k = 0, e0 = n_exec;
        ex = exp_st(c, l, p, a0, a1, a2);
        m.frame(mk(c, l, p, a0, a1, a2));
        m.rd(ADDR_STATUS, st0, e);
        chk16("busy", {15'h0, ex == 16'h0000}, {15'h0, busy});
        st = st0;
        while (st === STATUS_BUSY && k < 400) begin
            m.rd(ADDR_STATUS, st, e);
            k++;
        end
        if (k >= 400) begin
            n_errors++;
            test_done();
        end
        chk16("status", ex, st);
        chk16("busy_end", 16'h0000, {15'h0, busy});
        m.rd(ADDR_LAST, d, e);
        chk16("last_code", c, d);
        chk16("exec_code", c, xcode);
        chk16("exec_pulses", {15'h0, ex == 0}, 16'(n_exec - e0));
        if (ex == 0 && c != CMD_READ_STATE) begin
            chk16("busy_status", STATUS_BUSY, st0);
            chk16("exec_arg", a0, xarg);
        end
        if (ex == 0 && c == CMD_SET_PASSWORD) pw_tb[a0[1:0]] = {a1, a2};
    endtask

    function automatic logic [31:0] rpw();
        logic [31:0] p;
        for (int i = 0; i < 4; i++) p[8*i+:8] = 8'h61 + 8'($urandom % 26);
        return p;
    endfunction

    // ---------------------------------------------------------------
    // Stimulus
    // ---------------------------------------------------------------
    initial begin
        logic [15:0] d, cd;
        logic e;
        logic [31:0] np;
        void'($urandom(32'h63e6));
        repeat (8) @(posedge ref_clk_in);
        #1 sys_rst_in = 1'b0;
        m.rd(ADDR_STATUS, d, e);
        chk16("status_reset", STATUS_IDLE, d);
        m.rd(16'h0000, d, e);
        chk16("unmapped_err", 16'h0001, {15'h0, e});
        m.wr(ADDR_STATUS, 16'h5555, e);
        chk16("ro_err", 16'h0001, {15'h0, e});
        do_cmd(CMD_READ_STATE, 16'h000a, 32'h0, 16'h0, 16'h0, 16'h0);
        do_cmd(CMD_OPEN_BREAKER, 16'h000a, pw_tb[0], 16'h7, 16'h0, 16'h0);
        lck = 1'b1;
        do_cmd(CMD_OPEN_BREAKER, 16'h0009, pw_tb[0], 16'h7, 16'h0, 16'h0);
        do_cmd(CMD_OPEN_BREAKER, 16'h000a, pw_tb[1], 16'h7, 16'h0, 16'h0);
        do_cmd(CMD_OPEN_BREAKER, 16'h000a, pw_tb[2] ^ 32'h1, 16'h7, 16'h0, 16'h0);
        do_cmd(CMD_OPEN_BREAKER, 16'h001e, pw_tb[2], 16'h3c, 16'h0, 16'h0);
        do_cmd(CMD_SET_PASSWORD, 16'h000a, pw_tb[2], 16'h3, 16'h4142, 16'h4344);
        do_cmd(CMD_SET_PASSWORD, 16'h000a, pw_tb[0], 16'h3, 16'h4142, 16'h2344);
        do_cmd(CMD_SET_PASSWORD, 16'h000a, pw_tb[0], 16'h3, 16'h7a5a, 16'h3039);
        do_cmd(CMD_OPEN_BREAKER, 16'h000a, 32'h7a5a3039, 16'h9, 16'h0, 16'h0);
        do_cmd(CMD_CLOSE_BREAKER, 16'h000a, pw_tb[3], 16'h5, 16'h0, 16'h0);
        do_cmd(CMD_CLOSE_BREAKER, 16'h000a, pw_tb[1], 16'h5, 16'h0, 16'h0);
        drw = 1'b1;
        do_cmd(CMD_OPEN_BREAKER, 16'h000a, pw_tb[0], 16'h9, 16'h0, 16'h0);
        unl = 1'b1;
        m.frame(mk(CMD_OPEN_BREAKER, 16'h000a, pw_tb[0], 16'h1, 16'h0, 16'h0));
        repeat (20) @(posedge ref_clk_in);
        #1 do_cmd(CMD_OPEN_BREAKER, 16'h000a, pw_tb[0], 16'h2, 16'h0, 16'h0);
        for (int i = 0; i < 12; i++) begin
            lck = 1'($urandom);
            drw = 1'($urandom);
            unl = 1'($urandom);
            cd = ($urandom % 5 == 0) ? 16'h1234 : (($urandom % 2) ? CMD_SET_PASSWORD :
                 (($urandom % 2) ? CMD_OPEN_BREAKER : CMD_READ_STATE));
            np = ($urandom % 4 == 0) ? $urandom : rpw();
            do_cmd(cd, 16'h000a, ($urandom % 2) ? pw_tb[$urandom % 4] : rpw(),
                   16'($urandom % 4), np[31:16], np[15:0]);
        end
        chk16("rsp_count", 16'(n_req), 16'(n_rsp));
        test_done();
    end
endmodule // protected_command_interface_tb

`default_nettype wire

// File: inc/pci_pkg.sv
/*
 * Constants, types and helper functions for the protected command interface.
 * Assumes a register request port that carries one Modbus register access per
 * cycle, with a flag on the last word of a multiple-register write.
 */
// What this block does
// - Malformed or unauthorised commands report an error and change no configuration.
// - The hardware lock is checked before, and overrides, the password check.
// - Four profiles are kept: administrator, services, engineer, operator, each with a password.
// - Intrusive commands run only if the password matches an allowed profile.
// - Non-intrusive commands run with no password and ignore the lock.
// - A password is four characters from 0-9, a-z or A-Z.
// - A password changes with its own current password or the administrator's.
// - Default passwords are 0x30303030, 0x31313131, 0x32323232 and 0x33333333.
// - Intrusive commands need the lock pin open, or unlocked config on drawout variant.
// - Each command is identified by a numeric code; 904 opens the breaker.
// - The status register holds 0x0003 while a command executes.
// - The executed command code is published in the last-command register.
// - Status low byte is zero on success, else an error; 1 means bad password.
// - A command resent while one runs aborts the first instance.
// - Writing the command code register triggers execution with the following parameters.
// - On failure the status high byte carries the reporting module address.
`default_nettype none

package pci_pkg;

    // -------------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------------
    localparam int         CLK_PERIOD_NS = 8;
    localparam int         EXEC_TIME_NS  = 1000;
    localparam int         EXEC_CYCLES   = (EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] EXEC_LAST     = 8'(EXEC_CYCLES - 1);

    // -------------------------------------------------------------------------
    // Register map
    // -------------------------------------------------------------------------
    localparam logic [15:0] ADDR_CMD       = 16'h1f40;
    localparam logic [15:0] ADDR_BUF_END   = 16'h1f53;
    localparam logic [15:0] ADDR_LAST      = 16'h1f54;
    localparam logic [15:0] ADDR_STATUS    = 16'h1f55;
    localparam logic [15:0] ADDR_DBUF_SIZE = 16'h1f56;
    localparam int          BUF_WORDS      = 20;

    typedef logic [4:0] pci_idx_t;
    localparam pci_idx_t IDX_CODE  = 5'h00;
    localparam pci_idx_t IDX_LEN   = 5'h01;
    localparam pci_idx_t IDX_SEC   = 5'h03;
    localparam pci_idx_t IDX_PW_HI = 5'h04;
    localparam pci_idx_t IDX_PW_LO = 5'h05;
    localparam pci_idx_t IDX_ARG0  = 5'h06;
    localparam pci_idx_t IDX_ARG1  = 5'h07;
    localparam pci_idx_t IDX_ARG2  = 5'h08;
    localparam pci_idx_t IDX_RSV0  = 5'h10;
    localparam pci_idx_t IDX_RSV1  = 5'h11;
    localparam pci_idx_t IDX_RSV2  = 5'h12;
    localparam pci_idx_t IDX_RSV3  = 5'h13;

    localparam logic [15:0] PLEN_MIN  = 16'h000a;
    localparam logic [15:0] PLEN_MAX  = 16'h001e;
    localparam logic [15:0] SEC_OPEN  = 16'h0000;
    localparam logic [15:0] SEC_PW    = 16'h0001;
    localparam logic [15:0] RSV0_VAL  = 16'h0000;
    localparam logic [15:0] RSV1_VAL  = 16'h1f53;
    localparam logic [15:0] RSV2_VAL  = 16'h1f54;
    localparam logic [15:0] RSV3_VAL  = 16'h1f55;

    // -------------------------------------------------------------------------
    // Status and error codes
    // -------------------------------------------------------------------------
    localparam logic [15:0] STATUS_IDLE = 16'h0000;
    localparam logic [15:0] STATUS_BUSY = 16'h0003;
    localparam logic [7:0]  ERR_NONE    = 8'h00;
    localparam logic [7:0]  ERR_PASSWD  = 8'h01;
    localparam logic [7:0]  ERR_FORMAT  = 8'h0c;
    localparam logic [7:0]  ERR_UNKNOWN = 8'h0d;
    localparam logic [7:0]  ERR_LOCKED  = 8'h0e;

    // -------------------------------------------------------------------------
    // Profiles and passwords
    // -------------------------------------------------------------------------
    localparam logic [1:0] PROF_ADMIN = 2'h0;
    localparam logic [3:0] PROF_ALL   = 4'hf;
    localparam logic [3:0][31:0] PW_DEFAULTS = {32'h33333333, 32'h32323232,
                                                32'h31313131, 32'h30303030};

    // -------------------------------------------------------------------------
    // Command codes
    // -------------------------------------------------------------------------
    localparam logic [15:0] CMD_OPEN_BREAKER  = 16'h0388;
    localparam logic [15:0] CMD_CLOSE_BREAKER = 16'h0389;
    localparam logic [15:0] CMD_SET_PASSWORD  = 16'h0bb8;
    localparam logic [15:0] CMD_READ_STATE    = 16'h0001;

    typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_BUSY} pci_state_e;

    typedef struct packed {
        logic       known;
        logic       intrusive;
        logic [3:0] profiles;
    } pci_cmd_s;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        last;
        logic [15:0] addr;
        logic [15:0] data;
    } pci_req_s;

    typedef struct packed {
        logic        valid;
        logic        err;
        logic [15:0] data;
    } pci_rsp_s;

    function automatic pci_cmd_s cmd_lookup(input logic [15:0] code);
        pci_cmd_s c;
        c = '{known: 1'b0, intrusive: 1'b0, profiles: 4'h0};
        unique case (code)
            CMD_OPEN_BREAKER:  c = '{known: 1'b1, intrusive: 1'b1, profiles: 4'hd};
            CMD_CLOSE_BREAKER: c = '{known: 1'b1, intrusive: 1'b1, profiles: 4'hd};
            CMD_SET_PASSWORD:  c = '{known: 1'b1, intrusive: 1'b1, profiles: PROF_ALL};
            CMD_READ_STATE:    c = '{known: 1'b1, intrusive: 1'b0, profiles: 4'h0};
            default:           c = '{known: 1'b0, intrusive: 1'b0, profiles: 4'h0};
        endcase
        return c;
    endfunction

    function automatic logic pw_char_ok(input logic [7:0] ch);
        return (ch >= 8'h30 && ch <= 8'h39) || (ch >= 8'h41 && ch <= 8'h5a) ||
               (ch >= 8'h61 && ch <= 8'h7a);
    endfunction

    function automatic logic pw_format_ok(input logic [31:0] pw);
        return pw_char_ok(pw[31:24]) && pw_char_ok(pw[23:16]) &&
               pw_char_ok(pw[15:8]) && pw_char_ok(pw[7:0]);
    endfunction

endpackage

`default_nettype wire

// File: rtl/pci_cmd_if.sv
/*
 * Protected command interpreter: command buffer, checks, execution and status.
 * Assumes one register access per cycle on req_in, last set on the final word
 * of a multiple-register write, and lock inputs synchronous to the clock.
 */
`timescale 1ns/1ps
`default_nettype none

module pci_cmd_if
    import pci_pkg::*;
#(
    parameter logic [7:0] MODULE_ADDR = 8'h01
)(
    input  wire  logic        ref_clk_in,
    input  wire  logic        sys_rst_in,
    input  wire  pci_req_s    req_in,
    output pci_rsp_s          rsp_out,
    input  wire  logic        lock_open_in,
    input  wire  logic        drawout_variant_in,
    input  wire  logic        intrusive_unlocked_in,
    output logic              busy_out,
    output logic              exec_valid_out,
    output logic       [15:0] exec_code_out,
    output logic       [15:0] exec_arg_out
);

    // -------------------------------------------------------------------------
    // Register access decode
    // -------------------------------------------------------------------------
    logic [BUF_WORDS-1:0][15:0] buf_ff;
    logic [15:0]      last_ff, status_ff, code_ff, arg_ff;
    logic [31:0]      newpw_ff;
    logic [1:0]       tgt_ff;
    logic             setpw_ff, cmd_seen_ff, exec_ff;
    logic [7:0]       cnt_ff;
    pci_state_e       state_ff, nxt_state;
    pci_rsp_s         rsp_ff;
    logic [3:0][31:0] pw_all;

    wire       wr       = req_in.valid & req_in.write;
    wire       in_buf   = req_in.addr >= ADDR_CMD && req_in.addr <= ADDR_BUF_END;
    wire       pci_idx_t idx = pci_idx_t'(req_in.addr - ADDR_CMD);
    wire       buf_wr   = wr & in_buf;
    wire       wr_cmd   = wr & (req_in.addr == ADDR_CMD);
    // The trigger waits for the end of the frame so that all parameters are in.
    wire       trig     = wr & req_in.last & (cmd_seen_ff | wr_cmd);
    wire       mapped   = in_buf || req_in.addr == ADDR_LAST ||
                          req_in.addr == ADDR_STATUS || req_in.addr == ADDR_DBUF_SIZE;
    wire [15:0] rd_word = in_buf ? buf_ff[idx] :
                          req_in.addr == ADDR_LAST   ? last_ff :
                          req_in.addr == ADDR_STATUS ? status_ff : 16'h0000;

    // -------------------------------------------------------------------------
    // Command checks
    // -------------------------------------------------------------------------
    wire pci_cmd_s cmd    = cmd_lookup(buf_ff[IDX_CODE]);
    wire        is_setpw  = buf_ff[IDX_CODE] == CMD_SET_PASSWORD;
    wire [31:0] pw_sup    = {buf_ff[IDX_PW_HI], buf_ff[IDX_PW_LO]};
    wire [31:0] pw_new    = {buf_ff[IDX_ARG1], buf_ff[IDX_ARG2]};
    wire [1:0]  tgt       = buf_ff[IDX_ARG0][1:0];
    wire [15:0] sec_need  = cmd.intrusive ? SEC_PW : SEC_OPEN;
    wire fmt_ok = buf_ff[IDX_LEN] >= PLEN_MIN && buf_ff[IDX_LEN] <= PLEN_MAX &&
                  buf_ff[IDX_SEC] == sec_need &&
                  buf_ff[IDX_RSV0] == RSV0_VAL && buf_ff[IDX_RSV1] == RSV1_VAL &&
                  buf_ff[IDX_RSV2] == RSV2_VAL && buf_ff[IDX_RSV3] == RSV3_VAL;
    // The drawout variant has no locking pad, so its configuration bit stands in.
    wire lock_ok = drawout_variant_in ? intrusive_unlocked_in : lock_open_in;
    // Full 32-bit compares: a partial match must never pass.
    wire [3:0] pw_match = {pw_all[3] == pw_sup, pw_all[2] == pw_sup,
                           pw_all[1] == pw_sup, pw_all[0] == pw_sup};
    wire prof_ok  = |(cmd.profiles & pw_match);
    wire setpw_ok = pw_match[tgt] | pw_match[PROF_ADMIN];
    wire auth_ok  = is_setpw ? setpw_ok : prof_ok;
    // Lock is tested ahead of the password so hardware always decides.
    wire [7:0] chk_err = !cmd.known                  ? ERR_UNKNOWN :
                         !fmt_ok                     ? ERR_FORMAT  :
                         cmd.intrusive && !lock_ok   ? ERR_LOCKED  :
                         cmd.intrusive && !auth_ok   ? ERR_PASSWD  :
                         is_setpw && !pw_format_ok(pw_new) ? ERR_FORMAT : ERR_NONE;
    wire done    = state_ff == ST_BUSY && cnt_ff == EXEC_LAST && !trig;
    wire chk_bad = state_ff == ST_CHECK && !trig && chk_err != ERR_NONE;
    wire chk_go  = state_ff == ST_CHECK && !trig && chk_err == ERR_NONE;

    // -------------------------------------------------------------------------
    // Sequencer
    // -------------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE:  if (trig) nxt_state = ST_CHECK;
            ST_CHECK: nxt_state = trig ? ST_CHECK : (chk_bad ? ST_IDLE : ST_BUSY);
            // A resend restarts the check and drops the running instance.
            ST_BUSY:  nxt_state = trig ? ST_CHECK : (done ? ST_IDLE : ST_BUSY);
            default:  nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            buf_ff           <= '0;
            buf_ff[IDX_RSV1] <= RSV1_VAL;
            buf_ff[IDX_RSV2] <= RSV2_VAL;
            buf_ff[IDX_RSV3] <= RSV3_VAL;
            cmd_seen_ff      <= 1'b0;
        end else begin
            if (buf_wr) buf_ff[idx] <= req_in.data;
            if (wr) cmd_seen_ff <= wr_cmd & ~req_in.last | cmd_seen_ff & ~req_in.last;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            state_ff <= ST_IDLE;
            cnt_ff   <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= (state_ff == ST_BUSY && !trig) ? cnt_ff + 8'h01 : 8'h00;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            code_ff  <= 16'h0000;
            arg_ff   <= 16'h0000;
            newpw_ff <= 32'h00000000;
            tgt_ff   <= 2'h0;
            setpw_ff <= 1'b0;
        end else if (chk_go) begin
            code_ff  <= buf_ff[IDX_CODE];
            arg_ff   <= buf_ff[IDX_ARG0];
            newpw_ff <= pw_new;
            tgt_ff   <= tgt;
            setpw_ff <= is_setpw;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            status_ff <= STATUS_IDLE;
            last_ff   <= 16'h0000;
            exec_ff   <= 1'b0;
        end else begin
            exec_ff <= done;
            if (trig) begin
                status_ff <= STATUS_BUSY;
            end else if (chk_bad) begin
                status_ff <= {MODULE_ADDR, chk_err};
                last_ff   <= buf_ff[IDX_CODE];
            end else if (done) begin
                status_ff <= STATUS_IDLE;
                last_ff   <= code_ff;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            rsp_ff <= '0;
        end else begin
            rsp_ff.valid <= req_in.valid;
            rsp_ff.err   <= req_in.valid & (!mapped | (req_in.write & !in_buf));
            rsp_ff.data  <= (req_in.valid & !req_in.write) ? rd_word : 16'h0000;
        end
    end

    // Passwords only move on a completed, authorised change.
    pci_pw_store u_store (
        .ref_clk_in (ref_clk_in),
        .sys_rst_in (sys_rst_in),
        .wr_en_in   (done & setpw_ff),
        .wr_idx_in  (tgt_ff),
        .wr_pw_in   (newpw_ff),
        .pw_all_out (pw_all)
    );

    assign rsp_out        = rsp_ff;
    assign busy_out       = state_ff != ST_IDLE;
    assign exec_valid_out = exec_ff;
    assign exec_code_out  = last_ff;
    assign exec_arg_out   = arg_ff;

    // -------------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);

    logic [7:0] busy_age_ff;
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) busy_age_ff <= 8'h00;
        else busy_age_ff <= (state_ff == ST_BUSY && !trig) ? busy_age_ff + 8'h01 : 8'h00;
    end

    busy_status_a: assert property (state_ff != ST_IDLE |-> status_ff == STATUS_BUSY)
        else $error("status not busy while a command runs");
    lock_first_a: assert property (state_ff == ST_CHECK && !trig && cmd.known && fmt_ok &&
            cmd.intrusive && !lock_ok |=> status_ff[7:0] == ERR_LOCKED)
        else $error("closed lock did not block an intrusive command");
    pw_reject_a: assert property (state_ff == ST_CHECK && !trig && cmd.known && fmt_ok &&
            cmd.intrusive && lock_ok && !auth_ok |=> status_ff == {MODULE_ADDR, ERR_PASSWD})
        else $error("wrong password was not rejected with code 1");
    open_cmd_a: assert property (state_ff == ST_CHECK && !trig && cmd.known && fmt_ok &&
            !cmd.intrusive |=> state_ff == ST_BUSY)
        else $error("non-intrusive command was not executed");
    fmt_reject_a: assert property (state_ff == ST_CHECK && !trig && cmd.known && !fmt_ok
            |=> status_ff[7:0] == ERR_FORMAT && state_ff == ST_IDLE)
        else $error("malformed buffer was not rejected");
    last_code_a: assert property (exec_valid_out |-> last_ff == code_ff &&
            status_ff == STATUS_IDLE)
        else $error("completion did not publish code and success");
    exec_len_a: assert property (exec_valid_out |-> $past(busy_age_ff) == EXEC_LAST)
        else $error("execution time is wrong");
    run_abort_a: assert property (trig && state_ff == ST_BUSY |=> state_ff == ST_CHECK &&
            !exec_valid_out)
        else $error("resend did not abort the running command");
    pw_stable_a: assert property (!$past(done & setpw_ff) |-> $stable(pw_all))
        else $error("password changed without an authorised command");
    pw_format_a: assert property (done && setpw_ff |-> pw_format_ok(newpw_ff))
        else $error("badly formed password was stored");
    pw_reset_a: assert property ($past(sys_rst_in) |-> pw_all == PW_DEFAULTS)
        else $error("passwords not at factory values after reset");
    exec_finish_a: assert property ($rose(state_ff == ST_BUSY) |-> ##[1:130]
            (exec_valid_out || state_ff != ST_BUSY))
        else $error("command never finished");

    open_ok_c: cover property (exec_valid_out && last_ff == CMD_OPEN_BREAKER);
    pw_bad_c:  cover property (status_ff[7:0] == ERR_PASSWD);
    setpw_c:   cover property (done && setpw_ff);
    abort_c:   cover property (trig && state_ff == ST_BUSY);

endmodule // pci_cmd_if

`default_nettype wire

// File: rtl/pci_pw_store.sv
/*
 * Password store for the four user profiles.
 * Assumes the caller has already authorised and format-checked any write.
 */
`timescale 1ns/1ps
`default_nettype none

module pci_pw_store
    import pci_pkg::*;
(
    input  wire  logic             ref_clk_in,
    input  wire  logic             sys_rst_in,
    input  wire  logic             wr_en_in,
    input  wire  logic [1:0]       wr_idx_in,
    input  wire  logic [31:0]      wr_pw_in,
    output logic       [3:0][31:0] pw_all_out
);

    logic [3:0][31:0] pw_ff;

    // One slot per profile, factory values on reset.
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            pw_ff <= PW_DEFAULTS;
        end else if (wr_en_in) begin
            pw_ff[wr_idx_in] <= wr_pw_in;
        end
    end

    assign pw_all_out = pw_ff;

endmodule // pci_pw_store

`default_nettype wire
